// ===== hw/srb_cfg.svh
// Constants of the reset, break and wait status registers.
// Assumes an eight-bit register port with a two-bit register index.
`ifndef SRB_CFG_SVH
`define SRB_CFG_SVH

// =====================================================================
// Register indices
// =====================================================================
`define SRB_ADDR_W          2
`define SRB_ADDR_BRK_WAIT   2'h0
`define SRB_ADDR_RST_SRC    2'h1
`define SRB_ADDR_BRK_CTRL   2'h2

// =====================================================================
// Field positions
// =====================================================================
`define SRB_BIT_BREAK_WAIT  0
`define SRB_BIT_BRK_CLR_EN  0
`define SRB_BIT_POWER_UP    7
`define SRB_BIT_EXT_PIN     6
`define SRB_BIT_WATCHDOG    5
`define SRB_BIT_ILL_INSTR   4
`define SRB_BIT_ILL_ADDR    3
`define SRB_BIT_LOW_VOLT    2

// =====================================================================
// Reset values
// =====================================================================
`define SRB_RST_SRC_POR     6'h20
`define SRB_RST_BRK_WAIT    1'b0
`define SRB_RST_BRK_CLR_EN  1'b0
`define SRB_RDATA_ZERO      8'h00

`endif

// ===== hw/srb_pkg.sv
// Types of the reset, break and wait status registers.
// Assumes the constants of srb_cfg.svh.
package srb_pkg;

    // =================================================================
    // Reset-source flags, most significant first.
    // =================================================================
    typedef struct packed {
        logic power_up;
        logic ext_pin;
        logic watchdog;
        logic ill_instr;
        logic ill_addr;
        logic low_volt;
    } srb_src_flags_t;

    // =================================================================
    // State of the reset-source capture.
    // =================================================================
    typedef struct packed {
        logic           pin_s1;
        logic           pin_s2;
        logic           pin_s3;
        logic           pin_lvl;
        srb_src_flags_t flags;
    } srb_src_state_t;

    // =================================================================
    // State of the register bank.
    // =================================================================
    typedef struct packed {
        logic       break_wait_flag;
        logic       break_clear_enable;
        logic [7:0] rdata;
    } srb_bank_state_t;

endpackage : srb_pkg

// ===== hw/srb_regs.sv
// Reset-source, break-wait and break flag-control registers of the system unit.
// Assumes a same-clock core register port with a registered read answer.
// How it works
// RULE1: The break-wait bit reads 1 when the last wait was ended by a break, else 0.
// RULE2: Writing 0 to the break-wait bit clears it, and every reset clears it.
// RULE3: The reset-source register holds six independent cause flags.
// RULE4: Reading the reset-source register clears all its flags.
// RULE5: Power-on reset sets the power-up flag and clears the other five.
// RULE6: A reset from the external pin sets the pin flag.
// RULE7: A watchdog time-out reset sets the watchdog flag.
// RULE8: An illegal-instruction reset sets the illegal-instruction flag.
// RULE9: Only an opcode fetch from an illegal address sets the illegal-address flag.
// RULE10: A low-voltage reset sets the low-voltage flag.
// RULE11: With the clear-enable bit at 1 flags clear during break, at 0 they hold.
// RULE12: The clear-enable bit is readable and writable.
// RULE13: Break software reads break-wait and backs the stacked return address up by one.
// RULE14: A break arriving while the core waits sets the break-wait bit.
// RULE15: A flag cleared during an enabled break stays cleared after break.
// RULE16: Two-step clears stay protected in break and complete normally after it.
// RULE17: Each register is eight bits and unused bits read zero and ignore writes.
`timescale 1ns/1ps
`include "srb_cfg.svh"

module srb_regs (
    input  wire logic                       mclk_i,
    input  wire logic                       resetn_i,
    input  wire logic [`SRB_ADDR_W-1:0]     reg_addr_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    input  wire logic [7:0]                 reg_wdata_i,
    output logic      [7:0]                 reg_rdata_o,
    input  wire logic                       rst_pin_n_i,
    input  wire logic                       watchdog_timeout_i,
    input  wire logic                       illegal_opcode_i,
    input  wire logic                       illegal_addr_i,
    input  wire logic                       opcode_fetch_i,
    input  wire logic                       low_voltage_i,
    input  wire logic                       wait_mode_i,
    input  wire logic                       break_irq_i,
    input  wire logic                       break_state_i,
    output logic                            break_wait_flag_o,
    output logic                            status_clear_allow_o
);

    srb_pkg::srb_bank_state_t st_r;
    srb_pkg::srb_bank_state_t st_nxt;
    srb_pkg::srb_src_flags_t  src_flags;
    logic                     rst_evt;
    logic                     clr_allow;
    logic                     rd_src;
    logic [7:0]               src_byte;

    // =================================================================
    // Clear permission seen by every status flag
    // =================================================================
    // Outside break clears always act; in break only with clear-enable set.
    // Other modules gate each clearing step with this at the time of that
    // step, so a first step taken before break cannot finish inside it.
    assign clr_allow            = !break_state_i || st_r.break_clear_enable;    // RULE11
    assign status_clear_allow_o = clr_allow;                                    // RULE16

    // Read side effect is itself a flag clear and so obeys the break guard.
    assign rd_src = reg_rd_i && (reg_addr_i == `SRB_ADDR_RST_SRC) && clr_allow; // RULE11

    // =================================================================
    // Reset-source capture
    // =================================================================
    srb_rst_src u_rst_src (
        .mclk_i             (mclk_i),
        .resetn_i           (resetn_i),
        .rst_pin_n_i        (rst_pin_n_i),
        .watchdog_timeout_i (watchdog_timeout_i),
        .illegal_opcode_i   (illegal_opcode_i),
        .illegal_addr_i     (illegal_addr_i),
        .opcode_fetch_i     (opcode_fetch_i),
        .low_voltage_i      (low_voltage_i),
        .rd_clear_i         (rd_src),
        .flags_o            (src_flags),
        .rst_evt_o          (rst_evt)
    );

    always_comb begin
        src_byte                      = `SRB_RDATA_ZERO;
        src_byte[`SRB_BIT_POWER_UP]   = src_flags.power_up;
        src_byte[`SRB_BIT_EXT_PIN]    = src_flags.ext_pin;
        src_byte[`SRB_BIT_WATCHDOG]   = src_flags.watchdog;
        src_byte[`SRB_BIT_ILL_INSTR]  = src_flags.ill_instr;
        src_byte[`SRB_BIT_ILL_ADDR]   = src_flags.ill_addr;
        src_byte[`SRB_BIT_LOW_VOLT]   = src_flags.low_volt;
    end

    // =================================================================
    // Next state
    // =================================================================
    always_comb begin
        st_nxt = st_r;

        // Break-wait clear by writing 0, only while clears are allowed.
        if (reg_wr_i && (reg_addr_i == `SRB_ADDR_BRK_WAIT) && clr_allow
            && !reg_wdata_i[`SRB_BIT_BREAK_WAIT]) begin
            st_nxt.break_wait_flag = 1'b0;                                      // RULE2
        end
        // A break ending wait sets the bit and wins over a write clear, not over a reset.
        if (break_irq_i && wait_mode_i) begin
            st_nxt.break_wait_flag = 1'b1;                                      // RULE14
        end

        if (reg_wr_i && (reg_addr_i == `SRB_ADDR_BRK_CTRL)) begin
            st_nxt.break_clear_enable = reg_wdata_i[`SRB_BIT_BRK_CLR_EN];       // RULE12
        end

        // Registered read answer; unused bits and unmapped indices give 0.
        st_nxt.rdata = `SRB_RDATA_ZERO;                                         // RULE17
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `SRB_ADDR_BRK_WAIT: begin
                    st_nxt.rdata[`SRB_BIT_BREAK_WAIT] = st_r.break_wait_flag;   // RULE1
                end
                `SRB_ADDR_RST_SRC: begin
                    st_nxt.rdata = src_byte;                                    // RULE4
                end
                `SRB_ADDR_BRK_CTRL: begin
                    st_nxt.rdata[`SRB_BIT_BRK_CLR_EN] = st_r.break_clear_enable;
                end
                default: begin
                    st_nxt.rdata = `SRB_RDATA_ZERO;
                end
            endcase
        end

        // Any system reset returns the bank to its reset state.
        if (rst_evt || !resetn_i) begin
            st_nxt.break_wait_flag    = `SRB_RST_BRK_WAIT;                      // RULE2
            st_nxt.break_clear_enable = `SRB_RST_BRK_CLR_EN;
            st_nxt.rdata              = `SRB_RDATA_ZERO;
        end
    end

    // =================================================================
    // State register
    // =================================================================
    // Flags hold their value unless a set or clear acts, so a clear made in an
    // enabled break simply persists after break ends.
    always_ff @(posedge mclk_i) begin
        st_r <= st_nxt;                                                         // RULE15
    end

    assign reg_rdata_o       = st_r.rdata;
    assign break_wait_flag_o = st_r.break_wait_flag;                            // RULE13

endmodule : srb_regs

// ===== hw/srb_rst_src.sv
// Reset-source capture: six flags naming the cause of the last reset.
// Assumes internal reset requests are same-clock pulses and the pin is asynchronous.
`timescale 1ns/1ps
`include "srb_cfg.svh"

module srb_rst_src (
    input  wire logic                   mclk_i,
    input  wire logic                   resetn_i,
    input  wire logic                   rst_pin_n_i,
    input  wire logic                   watchdog_timeout_i,
    input  wire logic                   illegal_opcode_i,
    input  wire logic                   illegal_addr_i,
    input  wire logic                   opcode_fetch_i,
    input  wire logic                   low_voltage_i,
    input  wire logic                   rd_clear_i,
    output srb_pkg::srb_src_flags_t     flags_o,
    output logic                        rst_evt_o
);

    srb_pkg::srb_src_state_t st_r;
    srb_pkg::srb_src_state_t st_nxt;
    srb_pkg::srb_src_flags_t evt;
    logic                    pin_fall;

    // =================================================================
    // Next state
    // =================================================================
    always_comb begin
        st_nxt        = st_r;
        // Pin level passes three flops; a change counts once two and three agree.
        st_nxt.pin_s1 = rst_pin_n_i;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.pin_s3 = st_r.pin_s2;
        if (st_r.pin_s2 == st_r.pin_s3) begin
            st_nxt.pin_lvl = st_r.pin_s3;
        end
        pin_fall = st_r.pin_lvl && (st_r.pin_s2 == st_r.pin_s3) && !st_r.pin_s3;

        evt           = '0;
        evt.ext_pin   = pin_fall;                              // RULE6
        evt.watchdog  = watchdog_timeout_i;                    // RULE7
        evt.ill_instr = illegal_opcode_i;                      // RULE8
        evt.ill_addr  = illegal_addr_i && opcode_fetch_i;      // RULE9
        evt.low_volt  = low_voltage_i;                         // RULE10
        rst_evt_o     = |evt;

        if (rst_evt_o) begin
            // A new reset replaces the record and wins over a read clear.
            st_nxt.flags = evt;                                // RULE3
        end else if (rd_clear_i) begin
            st_nxt.flags = '0;                                 // RULE4
        end

        if (!resetn_i) begin
            st_nxt.flags   = `SRB_RST_SRC_POR;                 // RULE5
            st_nxt.pin_s1  = 1'b1;
            st_nxt.pin_s2  = 1'b1;
            st_nxt.pin_s3  = 1'b1;
            st_nxt.pin_lvl = 1'b1;
        end
    end

    // =================================================================
    // State register
    // =================================================================
    always_ff @(posedge mclk_i) begin
        st_r <= st_nxt;
    end

    assign flags_o = st_r.flags;

endmodule : srb_rst_src

// ===== test/srb_core_model.sv
// Model of the core, reset sources and break logic around the bank.
// Assumes requests change just after a rising edge of mclk_i.
`timescale 1ns/1ps
`include "srb_cfg.svh"

module srb_core_model (
    input  wire logic                   mclk_i,
    input  wire logic [7:0]             reg_rdata_i,
    output logic [`SRB_ADDR_W-1:0]      reg_addr_o,
    output logic                        reg_wr_o,
    output logic                        reg_rd_o,
    output logic [7:0]                  reg_wdata_o,
    output logic                        rst_pin_n_o,
    output logic [5:0]                  evt_o,
    output logic                        wait_mode_o,
    output logic                        break_state_o
);
    // ==================================================================
    // Bus and event tasks
    // ==================================================================
    initial begin
        {reg_addr_o, reg_wr_o, reg_rd_o, reg_wdata_o, evt_o} = '0;
        {wait_mode_o, break_state_o, rst_pin_n_o} = 3'b001;
    end
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge mclk_i);
        reg_wr_o <= 1'b0;
        reg_wdata_o <= ~d;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge mclk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        #1 d = reg_rdata_i;
    endtask : rd
    task automatic pulse(input logic [5:0] m);
        @(posedge mclk_i);
        evt_o <= m;
        @(posedge mclk_i);
        evt_o <= 6'h00;
    endtask : pulse
    task automatic lvl(input logic w, input logic b);
        @(posedge mclk_i);
        wait_mode_o <= w;
        break_state_o <= b;
    endtask : lvl
    task automatic pin_reset();
        @(posedge mclk_i);
        rst_pin_n_o <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_pin_n_o <= 1'b1;
        repeat (6) @(posedge mclk_i);
    endtask : pin_reset
    // The break routine backs the return address up when this is 1.
    task automatic brk_ret(output logic dec);
        logic [7:0] d;
        rd(`SRB_ADDR_BRK_WAIT, d);
        dec = d[0];
    endtask : brk_ret
endmodule : srb_core_model

// ===== test/srb_regs_monitor.sv
// Checker for the status and control register bank, bound to srb_regs.
// Assumes one clock and the synchronous active-low reset of the bank.
`timescale 1ns/1ps
`include "srb_cfg.svh"

module srb_regs_monitor (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [`SRB_ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic rst_pin_n_i,
    input wire logic watchdog_timeout_i,
    input wire logic illegal_opcode_i,
    input wire logic illegal_addr_i,
    input wire logic opcode_fetch_i,
    input wire logic low_voltage_i,
    input wire logic wait_mode_i,
    input wire logic break_irq_i,
    input wire logic break_state_i,
    input wire logic break_wait_flag_o,
    input wire logic status_clear_allow_o
);
    // ==================================================================
    // Helpers
    // ==================================================================
    logic ila_f;
    logic ev;
    logic wbit;
    logic src_rd;
    logic bw_wr;
    assign ila_f = illegal_addr_i & opcode_fetch_i;
    assign ev = watchdog_timeout_i | illegal_opcode_i | ila_f | low_voltage_i;
    assign wbit = reg_wdata_i[0];
    assign src_rd = reg_rd_i && reg_addr_i == `SRB_ADDR_RST_SRC;
    assign bw_wr = reg_wr_i && reg_addr_i == `SRB_ADDR_BRK_WAIT;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // ==================================================================
    // Assertions
    // ==================================================================
    a_rdata_idle_zero: assert property (
        !reg_rd_i || reg_addr_i == 2'h3 |=> reg_rdata_o == 8'h00)
        else $error("read data not zero");
    a_bw_set_wait: assert property (
        break_irq_i && wait_mode_i && !ev |=> break_wait_flag_o)
        else $error("break-wait not set");
    a_evt_clears_bw: assert property (
        ev && !break_irq_i |=> !break_wait_flag_o)
        else $error("break-wait kept over reset");
    a_bw_write_clr: assert property (
        bw_wr && !wbit && status_clear_allow_o && !break_irq_i |=> !break_wait_flag_o)
        else $error("break-wait not cleared by write");
    a_bw_protect: assert property (
        bw_wr && break_wait_flag_o && !status_clear_allow_o && !ev |=> break_wait_flag_o)
        else $error("break-wait cleared while protected");
    a_read_clears: assert property (
        src_rd && status_clear_allow_o && !ev ##1 !ev ##1 src_rd && !ev
        |=> reg_rdata_o == 8'h00)
        else $error("reset-source not cleared by read");
    a_src_flags: assert property (
        ev && rst_pin_n_i ##1 !ev && !src_rd ##1 src_rd && !ev |=> reg_rdata_o == {2'b00,
        $past(watchdog_timeout_i, 3), $past(illegal_opcode_i, 3), $past(ila_f, 3),
        $past(low_voltage_i, 3), 2'b00})
        else $error("reset-source flags wrong");
    a_allow_follows: assert property (
        reg_wr_i && reg_addr_i == `SRB_ADDR_BRK_CTRL && !ev
        |=> status_clear_allow_o == (!break_state_i || $past(wbit)))
        else $error("clear allow wrong");
    c_bw_set: cover property (break_irq_i && wait_mode_i);
    c_src_read: cover property (ev ##2 src_rd);
    c_protect: cover property (bw_wr && !status_clear_allow_o);
endmodule : srb_regs_monitor

bind srb_regs srb_regs_monitor u_mon (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .rst_pin_n_i(rst_pin_n_i),
    .watchdog_timeout_i(watchdog_timeout_i), .illegal_opcode_i(illegal_opcode_i),
    .illegal_addr_i(illegal_addr_i), .opcode_fetch_i(opcode_fetch_i),
    .low_voltage_i(low_voltage_i), .wait_mode_i(wait_mode_i), .break_irq_i(break_irq_i),
    .break_state_i(break_state_i), .break_wait_flag_o(break_wait_flag_o),
    .status_clear_allow_o(status_clear_allow_o));

// ===== test/tb_top.sv
// Self-checking bench of srb_regs driven through srb_core_model.
// Assumes the checker is bound to the design from its own file.
`timescale 1ns/1ps

module tb_top;
    logic mclk_i;
    logic resetn_i;
    logic [1:0] addr;
    logic wr, rd, pin_n, wm, bs, bw, allow, dec;
    logic [7:0] wdata, rdata, d;
    logic [5:0] ev;
    int failures = 0;
    int comparisons = 0;
    srb_core_model core (.mclk_i(mclk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata), .rst_pin_n_o(pin_n),
        .evt_o(ev), .wait_mode_o(wm), .break_state_o(bs));
    srb_regs DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .rst_pin_n_i(pin_n), .watchdog_timeout_i(ev[0]), .illegal_opcode_i(ev[1]),
        .illegal_addr_i(ev[2]), .opcode_fetch_i(ev[3]), .low_voltage_i(ev[4]),
        .wait_mode_i(wm), .break_irq_i(ev[5]), .break_state_i(bs),
        .break_wait_flag_o(bw), .status_clear_allow_o(allow));
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic t_por();
        core.rd(2'h1, d);
        chk("source after power-on", 8'h80, d);
        core.rd(2'h1, d);
        chk("source second read", 8'h00, d);
        core.wr(2'h3, 8'hFF);
        core.rd(2'h3, d);
        chk("unmapped", 8'h00, d);
        $display("test por done");
    endtask : t_por
    task automatic t_src();
        logic [5:0] m [6] = '{6'h01, 6'h02, 6'h0C, 6'h10, 6'h04, 6'h13};
        logic [7:0] e [6] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h00, 8'h34};
        foreach (m[i]) begin
            core.pulse(m[i]);
            core.rd(2'h1, d);
            chk("source flags", e[i], d);
        end
        core.pin_reset();
        core.rd(2'h1, d);
        chk("source pin", 8'h40, d);
        $display("test sources done");
    endtask : t_src
    task automatic t_brk();
        core.pulse(6'h01);
        core.lvl(1'b1, 1'b0);
        core.pulse(6'h20);
        core.lvl(1'b0, 1'b1);
        core.brk_ret(dec);
        chk("break-wait bit", 8'h01, {7'h00, dec});
        core.rd(2'h1, d);
        core.rd(2'h1, d);
        chk("source held in break", 8'h20, d);
        core.wr(2'h0, 8'h00);
        #1 chk("break-wait port held", 8'h01, {7'h00, bw});
        chk("clear allow protected", 8'h00, {7'h00, allow});
        core.wr(2'h2, 8'hFF);
        core.rd(2'h2, d);
        chk("clear enable", 8'h01, d);
        chk("clear allow enabled", 8'h01, {7'h00, allow});
        core.wr(2'h0, 8'h00);
        core.lvl(1'b0, 1'b0);
        core.rd(2'h0, d);
        chk("break-wait after break", 8'h00, d);
        $display("test break done");
    endtask : t_brk
    task automatic t_rst();
        core.lvl(1'b1, 1'b0);
        core.pulse(6'h20);
        #1 chk("break-wait set", 8'h01, {7'h00, bw});
        core.pulse(6'h01);
        #1 chk("break-wait after watchdog", 8'h00, {7'h00, bw});
        core.pulse(6'h20);
        core.wr(2'h2, 8'h01);
        @(posedge mclk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1'b1;
        core.lvl(1'b0, 1'b0);
        core.rd(2'h0, d);
        chk("break-wait after reset", 8'h00, d);
        core.rd(2'h2, d);
        chk("clear enable after reset", 8'h00, d);
        core.rd(2'h1, d);
        chk("source after reset", 8'h80, d);
        $display("test reset done");
    endtask : t_rst
    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge mclk_i);
        failures++;
        tally_and_finish();
    end
    initial begin
        resetn_i = 1'b0;
        repeat (8) @(posedge mclk_i);
        resetn_i <= 1'b1;
        t_por();
        t_src();
        t_brk();
        t_rst();
        tally_and_finish();
    end
endmodule : tb_top
